//--- core/mtw_pkg.sv
// Purpose: shared constants and types of the two-wire management write path
// Assumes: core clock of 20 MHz
// Notes: event words carry a two-bit kind above one data byte
package mtw_pkg;
    // device bus address, write form and read form
    localparam logic [7:0] DEV_ADDR_WR = 8'ha0;
    localparam logic [7:0] DEV_ADDR_RD = 8'ha1;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam int MAX_BURST = 4;
    localparam logic [2:0] BURST_LAST = 3'h4;
    localparam int FIFO_DEPTH = 8;
    localparam int EV_W = 10;
    localparam int KIND_LSB = 8;
    // internal write cycle time in ms; value is a plain default
    localparam int INTERNAL_WRITE_CYCLE_TIME_MS = 5;
    localparam int CORE_CLK_KHZ = 20000;
    localparam int TWR_CYCLES = INTERNAL_WRITE_CYCLE_TIME_MS * CORE_CLK_KHZ;
    localparam logic SDA_LOW = 1'b0;
    localparam logic RST_IDLE = 1'b0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] TIMER_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {EV_MADDR, EV_DATA, EV_COMMIT, EV_ABORT} mtw_ev_t;
endpackage

//--- core/mtw_stream_if.sv
// Purpose: valid/ready word stream between the write path's own modules
// Assumes: one clock on both sides
// Notes: a word moves on a cycle with valid and ready both high
`timescale 1ns/1ps
interface mtw_stream_if #(parameter int W = 8) (input wire logic clk);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- core/mtw_fifo.sv
// Purpose: small first-in first-out buffer of event words
// Assumes: DEPTH is a power of two
// Notes: ready on the write side drops when full, so back-pressure reaches the source
`timescale 1ns/1ps
module mtw_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // fill and drain sides
    mtw_stream_if.snk wr,
    mtw_stream_if.src rd
);
    import mtw_pkg::*;
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wp, rp, next_wp, next_rp;
    logic push, pop, full, empty;

    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty = (wp == rp);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem[rp[AW-1:0]];
    assign push = wr.valid && !full;
    assign pop = rd.ready && !empty;

    always_comb begin
        next_wp = wp;
        next_rp = rp;
        if (push) begin
            next_wp = wp + 1'b1;
        end
        if (pop) begin
            next_rp = rp + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp[AW-1:0]] <= wr.data;
        end
    end

    a_fifo_fill_bound: assert property (@(posedge core_clk) disable iff (rst)
        (full && !pop) |=> full && (wp == $past(wp)))
        else $error("fifo took a word while full");
endmodule

//--- core/mtw_byte_write.sv
// Purpose: write path of a two-wire management slave: byte and burst writes into memory
// Assumes: bus pins sampled on link_clk, several times faster than the bus clock
// Notes: link logic faces the pins; core logic stages bytes and times the write cycle
// Notes on behaviour
// - after the memory address byte the slave acks low and then takes the next data byte.
// - the first data byte is answered with a low ack.
// - a repeated START in place of the closing STOP aborts the write and drops its bytes.
// - a proper closing STOP starts a self-timed write of the bytes lasting the write cycle time.
// - during the write cycle the slave ignores the bus and acks nothing.
// - up to four data bytes are taken after one device address and one memory address.
// - every data byte of a burst gets a low ack; the code leaves a fifth data byte unacked.
// - a burst not ended by STOP is aborted and its bytes dropped.
// - the address byte is 1010000 plus a read/write bit, so A0h writes and A1h reads.
// - bus traffic is answered only while module_select_n is low.
`timescale 1ns/1ps
module mtw_byte_write #(
    parameter int TWR_CYC = mtw_pkg::TWR_CYCLES
) (
    // clocks and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic link_clk,
    // management bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic module_select_n,
    // internal memory write port
    output logic mem_wr_en,
    output logic [7:0] mem_addr,
    output logic [7:0] mem_wr_data,
    output logic write_busy
);
    import mtw_pkg::*;

    typedef enum logic [2:0] {L_IDLE, L_DEV, L_MEMA, L_DATA, L_ACK, L_SKIP, L_HOLD} mtw_lstate_t;
    typedef enum logic [1:0] {C_COLLECT, C_WRITE, C_WAIT} mtw_cstate_t;

    // link side: reset and pin synchronisers
    logic [1:0] lrst_q;
    logic link_rst;
    logic [2:0] scl_q, sda_q, sel_q;
    logic [1:0] busy_q, hack_q;
    logic scl_s, sel_s, busy_s, hack_s;
    logic hack;
    logic scl_rise, scl_fall, sda_rise, sda_fall, bus_start, bus_stop;

    always_ff @(posedge link_clk) begin
        lrst_q <= {lrst_q[0], rst};
        scl_q <= {scl_q[1:0], scl_i};
        sda_q <= {sda_q[1:0], sda_i};
        sel_q <= {sel_q[1:0], module_select_n};
        busy_q <= {busy_q[0], write_busy};
        hack_q <= {hack_q[0], hack};
    end

    // only the second stage and its delayed copy feed any logic
    assign link_rst = lrst_q[1];
    assign scl_s = scl_q[1];
    assign sel_s = sel_q[1];
    assign busy_s = busy_q[1];
    assign hack_s = hack_q[1];
    assign scl_rise = scl_q[1] && !scl_q[2];
    assign scl_fall = !scl_q[1] && scl_q[2];
    assign sda_rise = sda_q[1] && !sda_q[2];
    assign sda_fall = !sda_q[1] && sda_q[2];
    assign bus_start = scl_s && sda_fall;
    assign bus_stop = scl_s && sda_rise;

    // link side: byte receiver
    mtw_lstate_t lst, next_lst, ack_ret, next_ack_ret;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg;
    logic [2:0] nbytes, next_nbytes;
    logic opened, next_opened, next_sda_oe, seen_busy, next_seen_busy;
    logic ev_req, next_ev_req;
    logic [EV_W-1:0] ev_word, next_ev_word;
    logic pending;

    // an event is in flight until the core echoes the toggle
    assign pending = ev_req ^ hack_s;
    assign sda_o = SDA_LOW;

    always_comb begin
        next_lst = lst;
        next_ack_ret = ack_ret;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_nbytes = nbytes;
        next_opened = opened;
        next_sda_oe = sda_oe;
        next_seen_busy = seen_busy;
        next_ev_req = ev_req;
        next_ev_word = ev_word;
        if (lst == L_HOLD) begin
            // bus input ignored until the write cycle has come and gone
            // ahead of select, so a deselect cannot cut the hold short
            next_sda_oe = 1'b0;
            if (busy_s) begin
                next_seen_busy = 1'b1;
            end else if (seen_busy) begin
                next_seen_busy = 1'b0;
                next_lst = L_IDLE;
            end
        end else if (sel_s) begin
            // deselect drops any open transfer
            if (opened && !pending) begin
                next_ev_req = !ev_req;
                next_ev_word = {EV_ABORT, BYTE_ZERO};
            end
            next_lst = L_IDLE;
            next_sda_oe = 1'b0;
            next_opened = 1'b0;
        end else if (bus_start) begin
            // repeated start inside a write throws the staged bytes away
            if (opened && !pending) begin
                next_ev_req = !ev_req;
                next_ev_word = {EV_ABORT, BYTE_ZERO};
            end
            next_lst = L_DEV;
            next_bitcnt = 4'h0;
            next_nbytes = 3'h0;
            next_opened = 1'b0;
            next_sda_oe = 1'b0;
        end else if (bus_stop) begin
            next_lst = L_IDLE;
            next_opened = 1'b0;
            next_sda_oe = 1'b0;
            // only a stop launches the memory write
            if (opened && nbytes != 3'h0 && !pending) begin
                next_ev_req = !ev_req;
                next_ev_word = {EV_COMMIT, BYTE_ZERO};
                next_lst = L_HOLD;
            end
        end else if (lst == L_ACK) begin
            if (scl_fall) begin
                next_sda_oe = 1'b0;
                next_lst = ack_ret;
            end
        end else if (lst != L_IDLE) begin
            if (scl_rise) begin
                next_shreg = {shreg[6:0], sda_q[1]};
                next_bitcnt = bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == BIT_LAST) begin
                next_bitcnt = 4'h0;
                next_lst = L_SKIP;
                case (lst)
                    L_DEV: begin
                        // only the write form of our address is answered
                        if (shreg == DEV_ADDR_WR) begin
                            next_sda_oe = 1'b1;
                            next_ack_ret = L_MEMA;
                            next_lst = L_ACK;
                        end
                    end
                    L_MEMA: begin
                        if (!pending) begin
                            next_ev_req = !ev_req;
                            next_ev_word = {EV_MADDR, shreg};
                            next_opened = 1'b1;
                            next_sda_oe = 1'b1;
                            next_ack_ret = L_DATA;
                            next_lst = L_ACK;
                        end
                    end
                    L_DATA: begin
                        // a fifth byte or a stalled crossing gets no ack
                        if (nbytes != BURST_LAST && !pending) begin
                            next_ev_req = !ev_req;
                            next_ev_word = {EV_DATA, shreg};
                            next_nbytes = nbytes + 3'h1;
                            next_sda_oe = 1'b1;
                            next_ack_ret = L_DATA;
                            next_lst = L_ACK;
                        end
                    end
                    default: begin
                        next_lst = L_SKIP;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            lst <= L_IDLE;
            ack_ret <= L_IDLE;
            bitcnt <= 4'h0;
            shreg <= BYTE_ZERO;
            nbytes <= 3'h0;
            opened <= RST_IDLE;
            sda_oe <= RST_IDLE;
            seen_busy <= RST_IDLE;
            ev_req <= RST_IDLE;
            ev_word <= '0;
        end else begin
            lst <= next_lst;
            ack_ret <= next_ack_ret;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            nbytes <= next_nbytes;
            opened <= next_opened;
            sda_oe <= next_sda_oe;
            seen_busy <= next_seen_busy;
            ev_req <= next_ev_req;
            ev_word <= next_ev_word;
        end
    end

    // core side: toggle handshake into the event fifo
    logic [1:0] req_q;
    logic next_hack;
    mtw_stream_if #(.W(EV_W)) ev_in (.clk(core_clk));
    mtw_stream_if #(.W(EV_W)) ev_out (.clk(core_clk));

    // ev_word is held still while the toggle is unanswered
    assign ev_in.valid = req_q[1] ^ hack;
    assign ev_in.data = ev_word;
    assign next_hack = (ev_in.valid && ev_in.ready) ? req_q[1] : hack;

    always_ff @(posedge core_clk) begin
        req_q <= {req_q[0], ev_req};
        if (rst) begin
            hack <= RST_IDLE;
        end else begin
            hack <= next_hack;
        end
    end

    mtw_fifo #(.W(EV_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .wr(ev_in),
        .rd(ev_out)
    );

    // core side: staging and timed memory write
    mtw_cstate_t cst, next_cst;
    logic [7:0] base, next_base;
    logic [2:0] cnt, next_cnt, idx, next_idx;
    logic [7:0] wbuf [MAX_BURST];
    logic [7:0] next_wbuf [MAX_BURST];
    logic [31:0] timer, next_timer;
    logic next_mem_wr_en, next_busy, take;
    logic [7:0] next_mem_addr, next_mem_wr_data;
    mtw_ev_t kind;

    // the fifo drains only while collecting, so it fills during a write
    assign ev_out.ready = (cst == C_COLLECT);
    assign take = ev_out.valid && ev_out.ready;
    assign kind = mtw_ev_t'(ev_out.data[EV_W-1:KIND_LSB]);

    always_comb begin
        next_cst = cst;
        next_base = base;
        next_cnt = cnt;
        next_idx = idx;
        next_wbuf = wbuf;
        next_timer = timer;
        next_mem_wr_en = 1'b0;
        next_mem_addr = mem_addr;
        next_mem_wr_data = mem_wr_data;
        case (cst)
            C_COLLECT: begin
                if (take) begin
                    case (kind)
                        EV_MADDR: begin
                            next_base = ev_out.data[7:0];
                            next_cnt = 3'h0;
                        end
                        EV_DATA: begin
                            if (cnt != BURST_LAST) begin
                                next_wbuf[cnt[1:0]] = ev_out.data[7:0];
                                next_cnt = cnt + 3'h1;
                            end
                        end
                        EV_COMMIT: begin
                            if (cnt != 3'h0) begin
                                next_cst = C_WRITE;
                                next_idx = 3'h0;
                            end
                        end
                        default: begin
                            next_cnt = 3'h0;
                        end
                    endcase
                end
            end
            C_WRITE: begin
                next_mem_wr_en = 1'b1;
                next_mem_addr = 8'(base + {5'h00, idx});
                next_mem_wr_data = wbuf[idx[1:0]];
                next_idx = idx + 3'h1;
                if (idx + 3'h1 == cnt) begin
                    next_cst = C_WAIT;
                    next_cnt = 3'h0;
                    next_timer = 32'(TWR_CYC - 1);
                end
            end
            C_WAIT: begin
                if (timer == TIMER_ZERO) begin
                    next_cst = C_COLLECT;
                end else begin
                    next_timer = timer - 32'h0000_0001;
                end
            end
            default: begin
                next_cst = C_COLLECT;
            end
        endcase
        next_busy = (next_cst != C_COLLECT);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            cst <= C_COLLECT;
            base <= BYTE_ZERO;
            cnt <= 3'h0;
            idx <= 3'h0;
            timer <= TIMER_ZERO;
            mem_wr_en <= RST_IDLE;
            mem_addr <= BYTE_ZERO;
            mem_wr_data <= BYTE_ZERO;
            write_busy <= RST_IDLE;
        end else begin
            cst <= next_cst;
            base <= next_base;
            cnt <= next_cnt;
            idx <= next_idx;
            timer <= next_timer;
            mem_wr_en <= next_mem_wr_en;
            mem_addr <= next_mem_addr;
            mem_wr_data <= next_mem_wr_data;
            write_busy <= next_busy;
        end
    end

    always_ff @(posedge core_clk) begin
        wbuf <= next_wbuf;
    end

    // checks, link domain
    a_deselect_quiet: assert property (@(posedge link_clk) disable iff (link_rst)
        sel_s |=> !sda_oe)
        else $error("sda driven while deselected");
    a_busy_no_ack: assert property (@(posedge link_clk) disable iff (link_rst)
        (busy_s && lst == L_HOLD) |=> !sda_oe && lst == L_HOLD)
        else $error("bus answered during write cycle");
    a_memaddr_ack: assert property (@(posedge link_clk) disable iff (link_rst)
        (lst == L_MEMA && scl_fall && bitcnt == BIT_LAST && !pending && !sel_s && !bus_start && !bus_stop)
        |=> sda_oe && lst == L_ACK && ev_word[EV_W-1:KIND_LSB] == EV_MADDR)
        else $error("memory address byte not acked");
    a_data_ack: assert property (@(posedge link_clk) disable iff (link_rst)
        (lst == L_DATA && scl_fall && bitcnt == BIT_LAST && nbytes < BURST_LAST && !pending
        && !sel_s && !bus_start && !bus_stop) |=> sda_oe ##1 sda_oe)
        else $error("data byte not acked");
    a_dev_addr_match: assert property (@(posedge link_clk) disable iff (link_rst)
        (lst == L_DEV && scl_fall && bitcnt == BIT_LAST && shreg != DEV_ADDR_WR) |=> !sda_oe)
        else $error("foreign address acked");
    a_rs_abort_posted: assert property (@(posedge link_clk) disable iff (link_rst)
        (bus_start && opened && !pending && !sel_s && lst != L_HOLD)
        |=> ev_word[EV_W-1:KIND_LSB] == EV_ABORT && $changed(ev_req))
        else $error("repeated start did not abort");

    // checks, core domain
    a_abort_drops: assert property (@(posedge core_clk) disable iff (rst)
        (take && kind == EV_ABORT) |=> cnt == 3'h0 && cst == C_COLLECT)
        else $error("aborted bytes kept");
    a_commit_writes: assert property (@(posedge core_clk) disable iff (rst)
        (take && kind == EV_COMMIT && cnt != 3'h0) |=> ##1 mem_wr_en && mem_addr == $past(base, 2))
        else $error("commit did not start the write");
    a_addr_step: assert property (@(posedge core_clk) disable iff (rst)
        (mem_wr_en && $past(mem_wr_en)) |-> mem_addr == 8'($past(mem_addr) + 8'h01))
        else $error("burst address not successive");
    a_burst_limit: assert property (@(posedge core_clk) disable iff (rst)
        (cst == C_WRITE) |-> cnt <= BURST_LAST && cnt != 3'h0)
        else $error("burst length out of range");
    a_twr_countdown: assert property (@(posedge core_clk) disable iff (rst)
        (cst == C_WAIT && timer != TIMER_ZERO) |=> cst == C_WAIT && write_busy && timer == $past(timer) - 1)
        else $error("write cycle cut short");

    c_burst_four: cover property (@(posedge core_clk) disable iff (rst)
        take && kind == EV_COMMIT && cnt == BURST_LAST);
    c_abort_full: cover property (@(posedge core_clk) disable iff (rst)
        take && kind == EV_ABORT && cnt != 3'h0);
    c_fifo_full: cover property (@(posedge core_clk) disable iff (rst) !ev_in.ready);
    c_hold_done: cover property (@(posedge link_clk) disable iff (link_rst)
        lst == L_HOLD ##1 lst == L_IDLE);
endmodule

//--- tb/mtw_host_model.sv
// Purpose: behavioural host master of the two-wire management bus
// Assumes: each hp() step is four core clock cycles; the bus clock is high for one step and low for two
// Notes: sda_drv high means released; the pull-up then gives a high line
`timescale 1ns/1ps
module mtw_host_model (
    // pacing clock
    input wire logic clk,
    // bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic hp();
        repeat (4) @(posedge clk);
    endtask
    // also gives a repeated start when entered with the clock low
    task automatic start();
        sda_drv <= 1'b1;
        hp();
        scl <= 1'b1;
        hp();
        sda_drv <= 1'b0;
        hp();
        scl <= 1'b0;
        hp();
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        hp();
        scl <= 1'b1;
        hp();
        sda_drv <= 1'b1;
        hp();
    endtask
    // msb first; ninth clock released so the slave can pull low
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic [8:0] bits;
        bits = {b, 1'b1};
        for (int i = 8; i >= 0; i--) begin
            sda_drv <= bits[i];
            hp();
            scl <= 1'b1;
            hp();
            if (i == 0) ack = sda_line;
            scl <= 1'b0;
            // data waits one hp() step so no edge races the clock fall
            hp();
        end
    endtask
endmodule

//--- tb/mtw_byte_write_tb.sv
// Purpose: self-checking bench of the two-wire byte and burst write path
// Assumes: write cycle time shortened through TWR_CYC
// Notes: memory port writes are collected in a queue and compared after each commit
`timescale 1ns/1ps
module mtw_byte_write_tb;
    import mtw_pkg::*;
    localparam int TWR_SIM = 400;
    localparam int TIME_LIMIT = 20000;
    logic core_clk, link_clk, rst, module_select_n, scl, sda_drv, sda_line;
    logic sda_o, sda_oe, mem_wr_en, write_busy, ack;
    logic [7:0] mem_addr, mem_wr_data;
    logic [15:0] wq[$];
    int n_errors = 0;
    int compares = 0;
    int cycles = 0;
    assign sda_line = sda_drv & (sda_oe ? sda_o : 1'b1);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // phase offset keeps the link clock unrelated to the core clock
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    mtw_byte_write #(.TWR_CYC(TWR_SIM)) u_mtw_byte_write (
        .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe(sda_oe), .module_select_n(module_select_n), .mem_wr_en(mem_wr_en),
        .mem_addr(mem_addr), .mem_wr_data(mem_wr_data), .write_busy(write_busy));
    mtw_host_model u_mtw_host_model (.clk(core_clk), .scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
    always @(posedge core_clk) begin
        if (mem_wr_en === 1'b1) wq.push_back({mem_addr, mem_wr_data});
        cycles++;
        if (cycles == TIME_LIMIT) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // opens a write; only the first four data bytes are expected to be acked
    task automatic send_write(input logic [7:0] maddr, input int n, input logic [7:0] d0);
        wq.delete();
        u_mtw_host_model.start();
        u_mtw_host_model.send_byte(DEV_ADDR_WR, ack);
        check("address ack", ack, 0);
        u_mtw_host_model.send_byte(maddr, ack);
        check("memory address ack", ack, 0);
        for (int k = 0; k < n; k++) begin
            u_mtw_host_model.send_byte(d0 + 8'(k), ack);
            check("data ack", ack, (k < MAX_BURST) ? 0 : 1);
        end
    endtask
    task automatic wait_busy(input logic level);
        int t;
        t = 0;
        while (write_busy !== level && t < 1000) begin
            @(posedge core_clk);
            t++;
        end
        check("busy wait", t < 1000, 1);
    endtask
    task automatic no_commit();
        repeat (100) @(posedge core_clk);
        check("busy idle", write_busy, 0);
        check("write count", wq.size(), 0);
    endtask
    task automatic t_byte();
        int t;
        send_write(8'h10, 1, 8'h5a);
        u_mtw_host_model.stop();
        wait_busy(1'b1);
        t = 0;
        while (write_busy === 1'b1 && t < 1000) begin
            @(posedge core_clk);
            t++;
        end
        check("busy length", t, 1 + TWR_SIM);
        check("write count", wq.size(), 1);
        check("byte write", wq[0], 16'h105a);
        $display("test byte write done");
    endtask
    // five bytes from the top of the map: fifth dropped, addresses wrap
    task automatic t_burst();
        send_write(8'hfe, 5, 8'h31);
        u_mtw_host_model.stop();
        wait_busy(1'b1);
        u_mtw_host_model.start();
        u_mtw_host_model.send_byte(DEV_ADDR_WR, ack);
        check("ack while busy", ack, 1);
        u_mtw_host_model.stop();
        wait_busy(1'b0);
        check("write count", wq.size(), MAX_BURST);
        for (int k = 0; k < MAX_BURST; k++) begin
            check("burst write", wq[k], {8'hfe + 8'(k), 8'h31 + 8'(k)});
        end
        $display("test burst write done");
    endtask
    task automatic t_abort();
        send_write(8'h20, 2, 8'h77);
        u_mtw_host_model.start();
        u_mtw_host_model.send_byte(DEV_ADDR_RD, ack);
        check("read address ack", ack, 1);
        u_mtw_host_model.stop();
        no_commit();
        send_write(8'h30, 0, 8'h00);
        u_mtw_host_model.stop();
        no_commit();
        $display("test abort done");
    endtask
    task automatic t_addr();
        logic [7:0] bad[3] = '{8'ha2, 8'h20, 8'he0};
        for (int k = 0; k < 3; k++) begin
            u_mtw_host_model.start();
            u_mtw_host_model.send_byte(bad[k], ack);
            check("foreign address ack", ack, 1);
            u_mtw_host_model.stop();
        end
        $display("test address done");
    endtask
    // deselect in mid-write drops it; nothing is answered while deselected
    task automatic t_desel();
        send_write(8'h40, 1, 8'h11);
        module_select_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        u_mtw_host_model.start();
        u_mtw_host_model.send_byte(DEV_ADDR_WR, ack);
        check("deselected ack", ack, 1);
        u_mtw_host_model.stop();
        no_commit();
        module_select_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        $display("test deselect done");
    endtask
    initial begin
        rst = 1'b1;
        module_select_n = 1'b0;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        repeat (20) @(posedge core_clk);
        t_byte();
        t_burst();
        t_abort();
        t_addr();
        t_desel();
        wrap_up();
    end
endmodule
